// ### rtl/bct_top.sv
// branch condition and AND test decoder of the core
// Behaviour
// [RULE1] taken branch loads pc plus two plus displacement; else falls through
// [RULE2] opcode 29 branches when half-carry is one; three cycles
// [RULE3] opcode 22 branches only when carry and zero are both clear
// [RULE4] opcode 24 branches when carry is clear
// [RULE5] opcode 2F branches when interrupt pin is high
// [RULE6] opcode 2E branches when interrupt pin is low
// [RULE7] opcodes 20..2F decode to the listed flag conditions
// [RULE8] AND test updates negative and zero from acc AND operand
// [RULE9] AND test leaves accumulator and operand unchanged; result discarded
// [RULE10] each AND test result bit is the AND of matching bits
// [RULE11] displacement is sign-extended; branches alter no flag
`timescale 1ns/1ns
module bct_top
    import bct_pkg::*;
#(
    parameter int unsigned PC_W = bct_pkg::BCT_PC_W
) (
    // clock and reset
    input  wire logic                           clk_sys_in,
    input  wire logic                           rst_in,
    // instruction issue
    input  wire logic                           start_in,
    input  wire logic [bct_pkg::BCT_DATA_W-1:0] opcode_in,
    input  wire logic [bct_pkg::BCT_DATA_W-1:0] disp_in,
    input  wire logic [PC_W-1:0]                pc_in,
    input  wire logic                           bit_test_in,
    // operands and core state
    input  wire logic [bct_pkg::BCT_DATA_W-1:0] flag_register_in,
    input  wire logic [bct_pkg::BCT_DATA_W-1:0] accumulator_in,
    input  wire logic [bct_pkg::BCT_DATA_W-1:0] operand_in,
    input  wire logic                           irq_pin_in,
    // results
    output logic                                done_out,
    output logic                                taken_out,
    output logic [PC_W-1:0]                     pc_out,
    output logic [bct_pkg::BCT_DATA_W-1:0]      flag_register_out,
    output logic [bct_pkg::BCT_DATA_W-1:0]      accumulator_out,
    output logic                                busy_out
);
    import bct_pkg::*;

    bct_state_t      state_q, state_d;
    logic [1:0]      cnt_q, cnt_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic [7:0]      flags_q, flags_d;
    logic [7:0]      acc_q, acc_d;
    logic            taken_q, taken_d;
    logic            done_q, done_d;
    logic            busy_q, busy_d;
    logic            pend_taken_q;
    logic [PC_W-1:0] pend_pc_q;

    bct_eval_if ev_if ();

    wire is_branch_w = (opcode_in >= BCT_OP_BASE) && (opcode_in <= BCT_OP_LAST);
    wire br_go_w     = start_in && !bit_test_in && is_branch_w && (state_q == BCT_IDLE);
    wire bt_go_w     = start_in && bit_test_in && (state_q == BCT_IDLE);

    assign ev_if.cond  = opcode_in[3:0];
    assign ev_if.flags = flag_register_in;
    assign ev_if.pin   = irq_pin_in;

    bct_cond_eval u_eval (
        .ev (ev_if.evaluator)
    );

    logic bt_neg_w;
    logic bt_zero_w;
    bct_bit_test #(.W(BCT_DATA_W)) u_bt (
        .acc_in   (accumulator_in),
        .opnd_in  (operand_in),
        .neg_out  (bt_neg_w),
        .zero_out (bt_zero_w)
    );

    // displacement sign-extended to pc width; wrap-around is intended
    wire [PC_W-1:0] disp_ext_w = {{(PC_W-BCT_DATA_W){disp_in[BCT_DATA_W-1]}}, disp_in}; // see [RULE11]
    wire [PC_W-1:0] fall_pc_w  = PC_W'(pc_in + BCT_PC_STEP);
    wire [PC_W-1:0] tgt_pc_w   = PC_W'(fall_pc_w + disp_ext_w);                    // see [RULE1]
    wire [PC_W-1:0] next_pc_w  = ev_if.taken ? tgt_pc_w : fall_pc_w;              // see [RULE1]

    // flag update for the AND test: only N and Z move
    logic [7:0] bt_flags_w;
    always_comb begin
        bt_flags_w             = flag_register_in;
        bt_flags_w[BCT_FLAG_N] = bt_neg_w;   // see [RULE8]
        bt_flags_w[BCT_FLAG_Z] = bt_zero_w;  // see [RULE8]
    end

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        pc_d    = pc_q;
        flags_d = flags_q;
        acc_d   = acc_q;
        taken_d = 1'b0;
        done_d  = 1'b0;
        case (state_q)
            BCT_IDLE: begin
                if (br_go_w) begin
                    // verdict and flags sampled at issue; flags pass unchanged
                    state_d = BCT_BUSY;
                    cnt_d   = 2'd1;
                    flags_d = flag_register_in;   // see [RULE11]
                    acc_d   = accumulator_in;
                end else if (bt_go_w) begin
                    flags_d = bt_flags_w;
                    acc_d   = accumulator_in;     // see [RULE9]
                    pc_d    = pc_q;
                    done_d  = 1'b1;
                end
            end
            BCT_BUSY: begin
                cnt_d = 2'(cnt_q + 2'd1);
                if (cnt_q == BCT_BR_LAST) begin   // see [RULE2]
                    state_d = BCT_DONE;
                    pc_d    = pend_pc_q;
                    taken_d = pend_taken_q;
                    done_d  = 1'b1;
                end
            end
            BCT_DONE: begin
                state_d = BCT_IDLE;
            end
            default: begin
                state_d = BCT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_q <= BCT_IDLE;
            cnt_q   <= 2'd0;
            pc_q    <= BCT_PC_RESET;
            flags_q <= BCT_FLAG_RESET;
            acc_q   <= 8'h00;
            taken_q <= 1'b0;
            done_q  <= 1'b0;
            busy_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            pc_q    <= pc_d;
            flags_q <= flags_d;
            acc_q   <= acc_d;
            taken_q <= taken_d;
            done_q  <= done_d;
            busy_q  <= busy_d;
        end
    end

    // verdict latched at issue so later input changes cannot alter it
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pend_taken_q <= 1'b0;
            pend_pc_q    <= BCT_PC_RESET;
        end else if (br_go_w) begin
            pend_taken_q <= ev_if.taken;
            pend_pc_q    <= next_pc_w;
        end
    end

    // busy follows the next state so the registered port matches the state decode
    assign busy_d            = (state_d != BCT_IDLE);
    assign done_out          = done_q;
    assign taken_out         = taken_q;
    assign pc_out            = pc_q;
    assign flag_register_out = flags_q;
    assign accumulator_out   = acc_q;
    assign busy_out          = busy_q;

    // ---------------- checks ----------------
    default clocking dc @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    chk_br_three_cycles: assert property ( // see [RULE2]
        br_go_w |=> !done_q ##1 !done_q ##1 done_q)
        else $error("branch result not on third cycle");

    chk_br_target: assert property ( // see [RULE1]
        br_go_w && ev_if.taken |-> ##3 pc_q == $past(tgt_pc_w, 3))
        else $error("taken branch pc wrong");

    chk_br_fall: assert property ( // see [RULE1]
        br_go_w && !ev_if.taken |-> ##3 pc_q == $past(fall_pc_w, 3) && !taken_q)
        else $error("untaken branch pc wrong");

    chk_higher_cond: assert property ( // see [RULE3]
        br_go_w && opcode_in == 8'h22 |->
        ev_if.taken == !(flag_register_in[BCT_FLAG_C] || flag_register_in[BCT_FLAG_Z]))
        else $error("higher branch verdict wrong");

    chk_hs_cond: assert property ( // see [RULE4]
        br_go_w && opcode_in == 8'h24 |-> ev_if.taken == !flag_register_in[BCT_FLAG_C])
        else $error("carry clear verdict wrong");

    chk_hcs_cond: assert property ( // see [RULE2]
        br_go_w && opcode_in == 8'h29 |-> ev_if.taken == flag_register_in[BCT_FLAG_H])
        else $error("half carry set verdict wrong");

    chk_pin_high: assert property ( // see [RULE5]
        br_go_w && opcode_in == 8'h2F |-> ##3 taken_q == $past(irq_pin_in, 3))
        else $error("pin high verdict wrong");

    chk_pin_low: assert property ( // see [RULE6]
        br_go_w && opcode_in == 8'h2E |-> ##3 taken_q == !$past(irq_pin_in, 3))
        else $error("pin low verdict wrong");

    chk_always_never: assert property ( // see [RULE7]
        br_go_w && opcode_in[7:1] == 7'h10 |-> ##3 taken_q == !$past(opcode_in[0], 3))
        else $error("always or never verdict wrong");

    chk_bt_flags: assert property ( // see [RULE8]
        bt_go_w |=> done_q && flags_q[BCT_FLAG_Z] == ~|($past(accumulator_in & operand_in))
                    && flags_q[BCT_FLAG_N] == $past(accumulator_in[7] & operand_in[7]))
        else $error("bit test flags wrong");

    chk_bt_keep: assert property ( // see [RULE9]
        bt_go_w |=> acc_q == $past(accumulator_in)
                    && flags_q[BCT_FLAG_C] == $past(flag_register_in[BCT_FLAG_C]))
        else $error("bit test altered accumulator or carry");

    chk_br_flags: assert property ( // see [RULE11]
        br_go_w |=> flags_q == $past(flag_register_in))
        else $error("branch altered flags");

    // remaining condition codes, judged on the registered verdict at the result edge
    chk_ls_cond: assert property ( // see [RULE7]
        br_go_w && opcode_in == 8'h23 |->
        ##3 taken_q == $past(flag_register_in[BCT_FLAG_C] | flag_register_in[BCT_FLAG_Z], 3))
        else $error("lower or same verdict wrong");

    chk_cs_cond: assert property ( // see [RULE7]
        br_go_w && opcode_in == 8'h25 |->
        ##3 taken_q == $past(flag_register_in[BCT_FLAG_C], 3))
        else $error("carry set verdict wrong");

    chk_ne_cond: assert property ( // see [RULE7]
        br_go_w && opcode_in == 8'h26 |->
        ##3 taken_q == !$past(flag_register_in[BCT_FLAG_Z], 3))
        else $error("zero clear verdict wrong");

    chk_eq_cond: assert property ( // see [RULE7]
        br_go_w && opcode_in == 8'h27 |->
        ##3 taken_q == $past(flag_register_in[BCT_FLAG_Z], 3))
        else $error("zero set verdict wrong");

    chk_hcc_cond: assert property ( // see [RULE7]
        br_go_w && opcode_in == 8'h28 |->
        ##3 taken_q == !$past(flag_register_in[BCT_FLAG_H], 3))
        else $error("half carry clear verdict wrong");

    chk_pl_cond: assert property ( // see [RULE7]
        br_go_w && opcode_in == 8'h2A |->
        ##3 taken_q == !$past(flag_register_in[BCT_FLAG_N], 3))
        else $error("negative clear verdict wrong");

    chk_mi_cond: assert property ( // see [RULE7]
        br_go_w && opcode_in == 8'h2B |->
        ##3 taken_q == $past(flag_register_in[BCT_FLAG_N], 3))
        else $error("negative set verdict wrong");

    chk_mc_cond: assert property ( // see [RULE7]
        br_go_w && opcode_in == 8'h2C |->
        ##3 taken_q == !$past(flag_register_in[BCT_FLAG_I], 3))
        else $error("mask clear verdict wrong");

    chk_ms_cond: assert property ( // see [RULE7]
        br_go_w && opcode_in == 8'h2D |->
        ##3 taken_q == $past(flag_register_in[BCT_FLAG_I], 3))
        else $error("mask set verdict wrong");

    // taken is only meaningful as a qualifier of the result pulse
    chk_taken_done: assert property ( // see [RULE1]
        taken_q |-> done_q)
        else $error("taken without done");

    // pc moves only with a result; an AND test or a refused request leaves it alone
    chk_pc_hold: assert property ( // see [RULE1]
        $changed(pc_q) |-> done_q)
        else $error("pc changed without result");

    // a request while a branch is in flight is dropped without side effects
    chk_busy_refuse: assert property ( // see [RULE11]
        state_q == BCT_BUSY && start_in |=> flags_q == $past(flags_q) && acc_q == $past(acc_q))
        else $error("request accepted while busy");

    // issue, two busy cycles, then the done state before idle
    chk_br_busy: assert property ( // see [RULE2]
        br_go_w |=> busy_q [*3] ##1 !busy_q)
        else $error("branch busy window wrong");

    chk_bt_one_cycle: assert property ( // see [RULE8]
        bt_go_w |=> !busy_q)
        else $error("bit test held busy");

    cov_taken: cover property (br_go_w && ev_if.taken ##3 done_q);
    cov_untaken: cover property (br_go_w && !ev_if.taken ##3 done_q);
    cov_pin_low: cover property (br_go_w && opcode_in == 8'h2E && !irq_pin_in ##3 taken_q);
    cov_back: cover property (br_go_w && disp_in[7] && ev_if.taken);
    cov_bt_zero: cover property (bt_go_w && bt_zero_w);
endmodule : bct_top

// ### rtl/bct_pkg.sv
// package: opcodes, flag positions and timing for the branch and bit-test decoder
package bct_pkg;
    localparam int unsigned BCT_DATA_W     = 8;
    localparam int unsigned BCT_PC_W       = 16;
    // flag register layout: 1 1 1 H I N Z C
    localparam int unsigned BCT_FLAG_C     = 0;
    localparam int unsigned BCT_FLAG_Z     = 1;
    localparam int unsigned BCT_FLAG_N     = 2;
    localparam int unsigned BCT_FLAG_I     = 3;
    localparam int unsigned BCT_FLAG_H     = 4;
    localparam logic [7:0]  BCT_OP_BASE    = 8'h20;
    localparam logic [7:0]  BCT_OP_LAST    = 8'h2F;
    localparam logic [3:0]  BCT_CC_ALWAYS  = 4'h0;
    localparam logic [3:0]  BCT_CC_NEVER   = 4'h1;
    localparam logic [3:0]  BCT_CC_HIGHER  = 4'h2;
    localparam logic [3:0]  BCT_CC_LS      = 4'h3;
    localparam logic [3:0]  BCT_CC_CCLR    = 4'h4;
    localparam logic [3:0]  BCT_CC_CSET    = 4'h5;
    localparam logic [3:0]  BCT_CC_ZCLR    = 4'h6;
    localparam logic [3:0]  BCT_CC_ZSET    = 4'h7;
    localparam logic [3:0]  BCT_CC_HCLR    = 4'h8;
    localparam logic [3:0]  BCT_CC_HSET    = 4'h9;
    localparam logic [3:0]  BCT_CC_NCLR    = 4'hA;
    localparam logic [3:0]  BCT_CC_NSET    = 4'hB;
    localparam logic [3:0]  BCT_CC_ICLR    = 4'hC;
    localparam logic [3:0]  BCT_CC_ISET    = 4'hD;
    localparam logic [3:0]  BCT_CC_PINLO   = 4'hE;
    localparam logic [3:0]  BCT_CC_PINHI   = 4'hF;
    localparam logic [15:0] BCT_PC_STEP    = 16'h0002;
    localparam logic [15:0] BCT_PC_RESET   = 16'h0000;
    localparam logic [7:0]  BCT_FLAG_RESET = 8'hE0;
    localparam int unsigned BCT_BR_CYCLES  = 3;
    localparam logic [1:0]  BCT_BR_LAST    = 2'(BCT_BR_CYCLES - 1);
    typedef enum logic [1:0] {
        BCT_IDLE = 2'b00,
        BCT_BUSY = 2'b01,
        BCT_DONE = 2'b10
    } bct_state_t;
endpackage : bct_pkg

// ### rtl/bct_eval_if.sv
// interface: branch condition inputs and verdict between decoder and evaluator
`timescale 1ns/1ns
interface bct_eval_if;
    logic [3:0] cond;
    logic [7:0] flags;
    logic       pin;
    logic       taken;
    modport requester (output cond, output flags, output pin, input taken);
    modport evaluator (input cond, input flags, input pin, output taken);
endinterface : bct_eval_if

// ### rtl/bct_cond_eval.sv
// condition evaluator for the relative branch group
`timescale 1ns/1ns
module bct_cond_eval (
    bct_eval_if.evaluator ev
);
    import bct_pkg::*;
    wire c_w = ev.flags[BCT_FLAG_C];
    wire z_w = ev.flags[BCT_FLAG_Z];
    wire n_w = ev.flags[BCT_FLAG_N];
    wire i_w = ev.flags[BCT_FLAG_I];
    wire h_w = ev.flags[BCT_FLAG_H];
    logic base_w;
    // odd codes are the complement of the even partner, the pin pair included
    always_comb begin
        case (ev.cond[3:1])
            3'd0:    base_w = 1'b1;                 // see [RULE7]
            3'd1:    base_w = ~(c_w | z_w);         // see [RULE3]
            3'd2:    base_w = ~c_w;                 // see [RULE4]
            3'd3:    base_w = ~z_w;
            3'd4:    base_w = ~h_w;                 // see [RULE2]
            3'd5:    base_w = ~n_w;
            3'd6:    base_w = ~i_w;
            3'd7:    base_w = ~ev.pin;              // see [RULE6]
            default: base_w = 1'b0;
        endcase
    end
    // pin pair: 2E low, 2F high, so the odd code inverts as well
    assign ev.taken = ev.cond[0] ? ~base_w : base_w; // see [RULE5] [RULE7]
endmodule : bct_cond_eval

// ### rtl/bct_bit_test.sv
// non-destructive AND test producing new N and Z
`timescale 1ns/1ns
module bct_bit_test #(
    parameter int unsigned W = 8
) (
    input  wire logic [W-1:0] acc_in,
    input  wire logic [W-1:0] opnd_in,
    output logic              neg_out,
    output logic              zero_out
);
    logic [W-1:0] and_w;
    assign and_w    = acc_in & opnd_in;  // see [RULE10]
    assign neg_out  = and_w[W-1];        // see [RULE8]
    assign zero_out = ~|and_w;
endmodule : bct_bit_test

// ### sim/bct_top_bench.sv
// self-checking bench for the branch condition and AND test decoder
`timescale 1ns/1ns
module bct_top_bench;
    import bct_pkg::*;
    logic        clk_sys_in       = 1'b0;
    logic        rst_in           = 1'b1;
    logic        start_in         = 1'b0;
    logic        bit_test_in      = 1'b0;
    logic        irq_pin_in       = 1'b0;
    logic [7:0]  opcode_in        = 8'h00;
    logic [7:0]  disp_in          = 8'h00;
    logic [7:0]  flag_register_in = 8'h00;
    logic [7:0]  accumulator_in   = 8'h00;
    logic [7:0]  operand_in       = 8'h00;
    logic [15:0] pc_in            = 16'h0000;
    logic        done_out;
    logic        taken_out;
    logic        busy_out;
    logic [15:0] pc_out;
    logic [7:0]  flag_register_out;
    logic [7:0]  accumulator_out;
    int          err_count        = 0;
    int          check_count      = 0;

    bct_top dut_u (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .start_in(start_in),
        .opcode_in(opcode_in), .disp_in(disp_in), .pc_in(pc_in),
        .bit_test_in(bit_test_in), .flag_register_in(flag_register_in),
        .accumulator_in(accumulator_in), .operand_in(operand_in),
        .irq_pin_in(irq_pin_in), .done_out(done_out), .taken_out(taken_out),
        .pc_out(pc_out), .flag_register_out(flag_register_out),
        .accumulator_out(accumulator_out), .busy_out(busy_out)
    );

    always #4 clk_sys_in = ~clk_sys_in;

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_sim;
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    // expected verdict worked out from the flag and pin conditions
    function automatic logic exp_taken(logic [3:0] cc, logic [7:0] f, logic p);
        logic c;
        logic z;
        c = f[BCT_FLAG_C];
        z = f[BCT_FLAG_Z];
        case (cc)
            4'h0: return 1'b1;
            4'h1: return 1'b0;
            4'h2: return !(c | z);
            4'h3: return c | z;
            4'h4: return !c;
            4'h5: return c;
            4'h6: return !z;
            4'h7: return z;
            4'h8: return !f[BCT_FLAG_H];
            4'h9: return f[BCT_FLAG_H];
            4'hA: return !f[BCT_FLAG_N];
            4'hB: return f[BCT_FLAG_N];
            4'hC: return !f[BCT_FLAG_I];
            4'hD: return f[BCT_FLAG_I];
            4'hE: return !p;
            default: return p;
        endcase
    endfunction : exp_taken

    // poke raises a request while busy, which must be ignored
    task automatic issue(input logic bt, input logic [7:0] op, input logic [7:0] d,
                         input logic [15:0] pc, input logic [7:0] fl, input logic pin,
                         input logic poke, output int n);
        n = 0;
        @(negedge clk_sys_in);
        {start_in, bit_test_in, opcode_in, disp_in, pc_in} = {1'b1, bt, op, d, pc};
        {flag_register_in, irq_pin_in} = {fl, pin};
        do begin
            @(negedge clk_sys_in);
            n++;
            start_in = poke && (n == 1);
            bit_test_in = start_in;
            if (n > 8) begin
                check("done timeout", 16'h0000, 16'h0001);
                end_sim();
            end
        end while (done_out !== 1'b1);
    endtask : issue

    task automatic br(input logic [7:0] op, input logic [7:0] d, input logic [15:0] pc,
                      input logic [7:0] fl, input logic pin, input logic poke);
        int   n;
        logic t;
        t = exp_taken(op[3:0], fl, pin);
        issue(1'b0, op, d, pc, fl, pin, poke, n);
        check("branch latency", 16'(n), 16'h0003);
        check("taken", {15'h0000, taken_out}, {15'h0000, t});
        check("next pc", pc_out,
              pc + BCT_PC_STEP + (t ? {{8{d[7]}}, d} : 16'h0000));
        check("branch flags", {8'h00, flag_register_out}, {8'h00, fl});
        check("busy at done", {15'h0000, busy_out}, 16'h0001);
        @(negedge clk_sys_in);
        check("busy after", {15'h0000, busy_out}, 16'h0000);
        check("done width", {15'h0000, done_out}, 16'h0000);
    endtask : br

    task automatic test_reset;
        check("reset pc", pc_out, BCT_PC_RESET);
        check("reset flags", {8'h00, flag_register_out}, {8'h00, BCT_FLAG_RESET});
        check("reset acc", {8'h00, accumulator_out}, 16'h0000);
        check("reset status", {14'h0000, done_out, busy_out}, 16'h0000);
    endtask : test_reset

    // every opcode against every H I N Z C pattern, pin both ways, pc wrapping
    task automatic test_conds;
        for (int op = 0; op < 16; op++) begin
            for (int k = 0; k < 32; k++) begin
                br(BCT_OP_BASE | 8'(op), 8'(k * 37), 16'hFFF0 + 16'(k),
                   {3'b111, 5'(k)}, 1'(k >> 1) ^ 1'(k >> 4), 1'b0);
            end
        end
    endtask : test_conds

    task automatic test_ignored;
        @(negedge clk_sys_in);
        {start_in, bit_test_in, opcode_in} = {1'b1, 1'b0, 8'h30};
        @(negedge clk_sys_in);
        start_in = 1'b0;
        repeat (4) begin
            @(negedge clk_sys_in);
            check("ignored opcode", {14'h0000, done_out, busy_out}, 16'h0000);
        end
    endtask : test_ignored

    // back-to-back AND tests: only N and Z move, accumulator is echoed
    task automatic test_bit;
        logic [7:0] av [4] = '{8'hF0, 8'h80, 8'h5A, 8'h00};
        logic [7:0] mv [4] = '{8'h0F, 8'hFF, 8'h5A, 8'hFF};
        logic [7:0] fl;
        logic [7:0] r;
        @(negedge clk_sys_in);
        for (int i = 0; i < 4; i++) begin
            fl = (i % 2) ? 8'hFF : 8'hE6;
            r = av[i] & mv[i];
            {start_in, bit_test_in, accumulator_in, operand_in} = {2'b11, av[i], mv[i]};
            flag_register_in = fl;
            @(negedge clk_sys_in);
            check("test done", {15'h0000, done_out}, 16'h0001);
            check("test flags", {8'h00, flag_register_out},
                  {8'h00, fl[7:3], r[7], r == 8'h00, fl[0]});
            check("test acc", {8'h00, accumulator_out}, {8'h00, av[i]});
        end
        {start_in, bit_test_in} = 2'b00;
    endtask : test_bit

    initial begin
        repeat (8) @(negedge clk_sys_in);
        rst_in = 1'b0;
        test_reset();
        test_conds();
        br(8'h20, 8'h80, 16'h0100, 8'hE0, 1'b0, 1'b1);
        test_ignored();
        test_bit();
        end_sim();
    end
endmodule : bct_top_bench
